// *** hdl/rcsr_pkg.sv ***
/*
  Constants for the reset-cause status register: bit positions, reset
  values, the single register offset and the AXI4-Lite response codes.
  Assumes a 32-bit AXI4-Lite data path with word-aligned registers.
*/
package rcsr_pkg;
  // Register offset and address width
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h000;
  localparam int FLAG_W = 10;

  // Field positions inside the flag word
  localparam int BIT_POWER_ON = 0;
  localparam int BIT_BROWNOUT = 1;
  localparam int BIT_IDLE_WAKE = 2;
  localparam int BIT_SLEEP_WAKE = 3;
  localparam int BIT_WATCHDOG = 4;
  localparam int BIT_SOFT_RESET = 6;
  localparam int BIT_PIN_RESET = 7;
  localparam int BIT_REG_KEEP = 8;
  localparam int BIT_CFG_MISMATCH = 9;

  // Implemented bits and value after power-on
  localparam logic [FLAG_W-1:0] IMPL_MASK = 10'h3DF;
  localparam logic [FLAG_W-1:0] FLAG_RST = 10'h003;

  // Response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/rcsr_flag_cell.sv ***
/*
  One sticky flag bit with a hardware set and a software write port.
  Assumes set and write are single-cycle, synchronous to the clock.
*/
`timescale 1ns/1ps
module rcsr_flag_cell #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic set_i,
  input wire logic we_i,
  input wire logic wdata_i,
  output logic q_o
);
  logic q_reg;
  logic q_next;

  // Hardware set outranks a software write in the same cycle
  assign q_next = set_i ? 1'b1 : (we_i ? wdata_i : q_reg);

  // Power-on reset loads RST_VAL; a software write of zero also clears the bit
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      q_reg <= RST_VAL;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule // rcsr_flag_cell

// *** hdl/rcsr_top.sv ***
/*
  Reset-cause status register with an AXI4-Lite slave port. Holds the
  sticky reset and wake flags and the regulator keep-on-in-sleep bit.
  Assumes rstn_i is the power-on reset, and that each cause input is a
  one-cycle pulse from the reset and power controller, synchronous to mclk_i.
*/
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module rcsr_top #(
  parameter int ADDR_W = rcsr_pkg::ADDR_W
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic cfg_mismatch_evt_i,
  input wire logic master_clear_pin_evt_i,
  input wire logic soft_reset_evt_i,
  input wire logic watchdog_expired_evt_i,
  input wire logic sleep_wake_evt_i,
  input wire logic idle_wake_evt_i,
  input wire logic brownout_evt_i,
  input wire logic sleep_mode_i,
  output logic regulator_on_o,
  output logic [rcsr_pkg::FLAG_W-1:0] reset_cause_flags_o
);
  localparam int FW = rcsr_pkg::FLAG_W;

  // Word-address match against the one mapped register
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a[ADDR_W-1:2] == rcsr_pkg::OFS_FLAGS[ADDR_W-1:2]);
  endfunction

  // Byte strobes widened to a bit mask over the flag field
  function automatic logic [FW-1:0] strb_mask(input logic [3:0] s);
    strb_mask = {{2{s[1]}}, {8{s[0]}}};
  endfunction

  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic aw_hold_reg, aw_hold_next;
  logic w_hold_reg, w_hold_next;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic regulator_on_reg;
  logic [FW-1:0] flag_q;
  logic [FW-1:0] hw_set;
  logic [FW-1:0] flag_we;
  logic [31:0] flag_word;
  logic aw_take, w_take, ar_take, commit, wr_hit;
  logic rd_hit;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;
  logic [1:0] bresp_next;

  // Write channel handshakes; address and data may come in either order
  assign aw_take = s_axi_awvalid_i & awready_reg;
  assign w_take = s_axi_wvalid_i & wready_reg;
  assign commit = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign wr_hit = addr_hit(awaddr_reg);
  assign bresp_next = wr_hit ? rcsr_pkg::RESP_OKAY : rcsr_pkg::RESP_SLVERR;
  assign aw_hold_next = (aw_hold_reg | aw_take) & ~commit;
  assign w_hold_next = (w_hold_reg | w_take) & ~commit;
  assign bvalid_next = commit | (bvalid_reg & ~s_axi_bready_i);
  // Ready drops while a half is parked, so one write at a time
  assign awready_next = ~aw_hold_next & ~bvalid_next;
  assign wready_next = ~w_hold_next & ~bvalid_next;

  // Read channel: one read outstanding, data registered
  assign ar_take = s_axi_arvalid_i & arready_reg;
  assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready_i);
  assign arready_next = ~rvalid_next;
  assign flag_word = {22'h00_0000, flag_q};
  // Read data and response picked at the address handshake
  assign rd_hit = addr_hit(s_axi_araddr_i);
  assign rdata_next = rd_hit ? flag_word : 32'h0000_0000;
  assign rresp_next = rd_hit ? rcsr_pkg::RESP_OKAY : rcsr_pkg::RESP_SLVERR;

  // Hardware event vector; bit 0 is set by the power-on reset value
  assign hw_set = {cfg_mismatch_evt_i,
                   1'b0,
                   master_clear_pin_evt_i,
                   soft_reset_evt_i,
                   1'b0,
                   watchdog_expired_evt_i,
                   sleep_wake_evt_i,
                   idle_wake_evt_i,
                   brownout_evt_i,
                   1'b0};
  // Lanes 2 and 3 hold no flags, so their strobes are ignored
  assign flag_we = {FW{commit & wr_hit}} & strb_mask(wstrb_reg);

  // Implemented bits get a cell, bit 5 has no storage
  genvar gi;
  generate
    for (gi = 0; gi < FW; gi++) begin : g_flag
      if (rcsr_pkg::IMPL_MASK[gi]) begin : g_cell
        rcsr_flag_cell #(
          .RST_VAL(rcsr_pkg::FLAG_RST[gi])
        ) u_cell (
          .mclk_i(mclk_i),
          .rstn_i(rstn_i),
          .set_i(hw_set[gi]),
          .we_i(flag_we[gi]),
          .wdata_i(wdata_reg[gi]),
          .q_o(flag_q[gi])
        );
      end else begin : g_none
        assign flag_q[gi] = 1'b0;
      end
    end
  endgenerate

  // Write path registers
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= rcsr_pkg::RESP_OKAY;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      bvalid_reg <= bvalid_next;
      if (commit) begin
        bresp_reg <= bresp_next;
      end
    end
  end

  // Payload capture; held values need no reset
  always_ff @(posedge mclk_i) begin
    if (aw_take) begin
      awaddr_reg <= s_axi_awaddr_i;
    end
    if (w_take) begin
      wdata_reg <= s_axi_wdata_i;
      wstrb_reg <= s_axi_wstrb_i;
    end
  end

  // Read path registers; unmapped reads return zero with an error
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= rcsr_pkg::RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rdata_next;
        rresp_reg <= rresp_next;
      end
    end
  end

  // Regulator stays on outside sleep; in sleep only if the keep bit is set
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      regulator_on_reg <= 1'b1;
    end else begin
      regulator_on_reg <= ~sleep_mode_i | flag_q[rcsr_pkg::BIT_REG_KEEP];
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign regulator_on_o = regulator_on_reg;
  assign reset_cause_flags_o = flag_q;

  // Checks on the flag and bus behaviour
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  property p_sets(evt, flag);
    evt |=> flag;
  endproperty

  AST_UPPER_ZERO: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:10] == 22'h00_0000)
    else $error("upper read bits not zero");
  AST_CFG_SET: assert property (p_sets(cfg_mismatch_evt_i, flag_q[9]))
    else $error("config mismatch flag not set");
  AST_REG_KEEP: assert property (!sleep_mode_i || flag_q[8] |=> regulator_on_o)
    else $error("regulator off while it should be on");
  AST_REG_OFF: assert property (sleep_mode_i && !flag_q[8] |=> !regulator_on_o)
    else $error("regulator on in sleep without keep bit");
  AST_PIN_SET: assert property (p_sets(master_clear_pin_evt_i, flag_q[7]))
    else $error("pin reset flag not set");
  AST_SOFT_SET: assert property (p_sets(soft_reset_evt_i, flag_q[6]))
    else $error("soft reset flag not set");
  AST_BIT5_ZERO: assert property (s_axi_rvalid_o |-> !s_axi_rdata_o[5])
    else $error("bit 5 read as one");
  AST_WDT_SET: assert property (p_sets(watchdog_expired_evt_i, flag_q[4]))
    else $error("watchdog flag not set");
  AST_SLEEP_SET: assert property (p_sets(sleep_wake_evt_i, flag_q[3]))
    else $error("sleep wake flag not set");
  AST_IDLE_SET: assert property (p_sets(idle_wake_evt_i, flag_q[2]))
    else $error("idle wake flag not set");
  AST_BROWNOUT_SET: assert property (p_sets(brownout_evt_i, flag_q[1]))
    else $error("brown-out flag not set");
  AST_POR_VALUE: assert property ($rose(rstn_i) |-> flag_q == 10'h003)
    else $error("wrong flag value after power-on");
  AST_STICKY: assert property (!(|hw_set) && !(|flag_we) |=> $stable(flag_q))
    else $error("flag changed without cause");
  AST_SET_WINS: assert property ((hw_set & flag_we) != 10'h000
    |=> (flag_q & $past(hw_set)) == $past(hw_set))
    else $error("software write beat a hardware set");
  AST_B_AFTER_BOTH: assert property (aw_take && w_take |=> ##1 s_axi_bvalid_o)
    else $error("write response late");

  // Bus handshake checks; answers stand until taken, one transfer at a time
  AST_BVALID_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before it was taken");
  AST_RVALID_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read data changed before it was taken");
  AST_AW_BLOCKED: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while a response is pending");
  AST_AR_BLOCKED: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while read data is pending");
  AST_B_ONCE: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("second write response without a write");
  AST_R_ONCE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("second read answer without a read");
  AST_UNMAPPED_WR: assert property (commit && !wr_hit
    |=> s_axi_bvalid_o && s_axi_bresp_o == rcsr_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_RD_ERR_ZERO: assert property (s_axi_rvalid_o && s_axi_rresp_o != rcsr_pkg::RESP_OKAY
    |-> s_axi_rdata_o == 32'h0000_0000)
    else $error("refused read returned data");
  AST_RD_DATA: assert property (ar_take && rd_hit
    |=> s_axi_rdata_o == {22'h00_0000, $past(flag_q)})
    else $error("read data differs from the flags");

  // Flag update checks
  AST_WRITE_LANDS: assert property (flag_we != 10'h000 && hw_set == 10'h000
    |=> (flag_q & $past(flag_we) & rcsr_pkg::IMPL_MASK)
        == ($past(wdata_reg[FW-1:0]) & $past(flag_we) & rcsr_pkg::IMPL_MASK))
    else $error("software write did not land");
  AST_FLAG_HOLD: assert property (1'b1
    |=> ($past(flag_q) & ~$past(flag_we) & ~flag_q) == 10'h000)
    else $error("set flag cleared without a write");
  AST_FLAG_RISE: assert property (1'b1
    |=> (flag_q & ~$past(flag_q) & ~$past(hw_set) & ~$past(flag_we)) == 10'h000)
    else $error("flag set without an event or a write");
  AST_POR_NO_EVT: assert property (!flag_q[0] && !flag_we[0] |=> !flag_q[0])
    else $error("power-on flag set outside reset");

  // Main scenarios
  COV_WRITE: cover property (commit && wr_hit);
  COV_READ: cover property (ar_take ##1 s_axi_rvalid_o && s_axi_rready_i);
  COV_SLEEP_KEEP: cover property (sleep_mode_i && flag_q[8] ##1 regulator_on_o);
  COV_SET_WINS: cover property ((hw_set & flag_we) != 10'h000);
  COV_UNMAPPED: cover property (commit && !wr_hit);
endmodule // rcsr_top

// *** sim/rcsr_tb.sv ***
/*
  Self-checking bench for the reset-cause status register.
  Assumes an AXI4-Lite slave that answers within a few cycles; the bench drives every input.
*/
`timescale 1ns/1ps
module rcsr_tb;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [6:0] evt = '0;
  logic sleep_mode = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, reg_on;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [9:0] flags;
  int err_count = 0;
  int n_compared = 0;
  // Flag bit set by each event input, same order as evt
  localparam int EVT_BIT [7] = '{9, 7, 6, 4, 3, 2, 1};

  rcsr_top dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .cfg_mismatch_evt_i(evt[0]), .master_clear_pin_evt_i(evt[1]),
    .soft_reset_evt_i(evt[2]), .watchdog_expired_evt_i(evt[3]),
    .sleep_wake_evt_i(evt[4]), .idle_wake_evt_i(evt[5]), .brownout_evt_i(evt[6]),
    .sleep_mode_i(sleep_mode), .regulator_on_o(reg_on), .reset_cause_flags_o(flags));

  // 40 MHz clock
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    d = rdata;
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  task automatic do_reset();
    rstn_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
  endtask

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far above the 130 or so cycles the tests need
  initial begin
    #(25 * 5000);
    err_count++;
    results();
  end

  initial begin
    do_reset();
    // Power-on value
    axi_rd(12'h000, rcsr_pkg::RESP_OKAY, rd);
    check("por", rd, 32'h0000_0003);
    check("reg_on", {31'h0, reg_on}, 32'h0000_0001);
    // Software clears the power-up flags after reading them
    axi_wr(12'h000, 32'h0000_0000, 4'hF, rcsr_pkg::RESP_OKAY);
    // Each event sets its own flag only and it sticks
    for (int i = 0; i < 7; i++) begin
      evt[i] <= 1'b1;
      @(posedge mclk_i);
      evt[i] <= 1'b0;
      repeat (3) @(posedge mclk_i);
      axi_rd(12'h000, rcsr_pkg::RESP_OKAY, rd);
      check("evt_flag", rd, 32'h1 << EVT_BIT[i]);
      check("flags_o", {22'h0, flags}, 32'h1 << EVT_BIT[i]);
      axi_wr(12'h000, 32'h0000_0000, 4'hF, rcsr_pkg::RESP_OKAY);
    end
    // All ones: unstored bits read zero
    axi_wr(12'h000, 32'hFFFF_FFFF, 4'hF, rcsr_pkg::RESP_OKAY);
    axi_rd(12'h000, rcsr_pkg::RESP_OKAY, rd);
    check("all_ones", rd, 32'h0000_03DF);
    // Lane 0 only leaves bits 9:8 alone
    axi_wr(12'h000, 32'h0000_0000, 4'h1, rcsr_pkg::RESP_OKAY);
    axi_rd(12'h000, rcsr_pkg::RESP_OKAY, rd);
    check("lane0", rd, 32'h0000_0300);
    // Unmapped address refused, nothing written
    axi_wr(12'h004, 32'h0000_0000, 4'hF, rcsr_pkg::RESP_SLVERR);
    axi_rd(12'h004, rcsr_pkg::RESP_SLVERR, rd);
    check("unmapped_rd", rd, 32'h0000_0000);
    axi_rd(12'h000, rcsr_pkg::RESP_OKAY, rd);
    check("unmapped_wr", rd, 32'h0000_0300);
    // Regulator keep bit against sleep
    sleep_mode <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check("keep_on", {31'h0, reg_on}, 32'h0000_0001);
    axi_wr(12'h000, 32'h0000_0000, 4'hF, rcsr_pkg::RESP_OKAY);
    repeat (3) @(posedge mclk_i);
    check("sleep_off", {31'h0, reg_on}, 32'h0000_0000);
    sleep_mode <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check("awake_on", {31'h0, reg_on}, 32'h0000_0001);
    // Hardware set wins over a clearing write; pulse lands in the commit cycle
    fork
      axi_wr(12'h000, 32'h0000_0000, 4'hF, rcsr_pkg::RESP_OKAY);
      begin
        @(posedge mclk_i);
        evt[3] <= 1'b1;
        @(posedge mclk_i);
        evt[3] <= 1'b0;
      end
    join
    axi_rd(12'h000, rcsr_pkg::RESP_OKAY, rd);
    check("set_wins", rd, 32'h0000_0010);
    // Second power-on reset mid-run
    do_reset();
    check("rst_again", {22'h0, flags}, 32'h0000_0003);
    axi_rd(12'h000, rcsr_pkg::RESP_OKAY, rd);
    check("rst_read", rd, 32'h0000_0003);
    results();
  end
endmodule // rcsr_tb
